// [rtl/auto_stage_consts.vh]
// Constants for the automatic stage sequencer: register map, fields, timing.
// Assumes a 10 MHz system clock and 32-bit AXI4-Lite register access.
`ifndef AUTO_STAGE_CONSTS_VH
`define AUTO_STAGE_CONSTS_VH
`define CLK_HZ 10000000
`define TENTH_SEC_CYC (`CLK_HZ / 10)
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_STAGE0_FREQ 12'h008
`define OFS_ACCEL 12'h00C
`define OFS_DECEL 12'h010
`define OFS_FREQ_BASE 12'h040
`define OFS_TIME_BASE 12'h080
`define OFS_DIR_BASE 12'h0C0
`define MODE_OFF 3'd0
`define DIR_STOP 2'd0
`define DIR_FWD 2'd1
`define DIR_REV 2'd2
`define FREQ_MAX 16'd40000
`define FREQ_COARSE 16'd30000
`define TIME_MAX 16'd60000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [rtl/auto_stage_sequencer.v]
// Automatic stage sequencer for a motor drive, AXI4-Lite register slave.
// Assumes run, wobble, PID and multi-step inputs are asynchronous pins.
// Functional notes
// - Modes 1 and 4 run the program once and stop, restart speed from stop point.
// - Modes 2 and 5 repeat the program endlessly, restart speed from stop point.
// - Modes 3 and 6 run once then hold the last stage's frequency and direction.
// - Modes 1 to 3 resume the unfinished stage when run returns.
// - Modes 4 to 6 restart from stage 0 when run returns.
// - Fifteen frequency settings for stages 1-15, sixteen times and directions 0-15.
// - Stage 0 frequency comes from the multi-speed zero setting.
// - Frequency 0.00-400.00 Hz in hundredths, tenths above 300 Hz.
// - Stage time 0.0-6000.0 s in tenth-second steps.
// - Direction 0 is stop, 1 forward, 2 reverse.
// - Wobble or PID enabled inhibits the sequencer.
// - All stage times zero inhibits the sequencer.
// - Multi-step selection inputs are ignored while the sequencer is enabled.
// - Ramping uses the primary acceleration and deceleration times only.
// - Mode 0 leaves the reference to the normal sources.
`timescale 1ns/10ps
`include "auto_stage_consts.vh"
module auto_stage_sequencer #(
  parameter TICK_CYC = `TENTH_SEC_CYC
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire run_in,
  input wire wobble_en_in,
  input wire pid_en_in,
  input wire [3:0] multi_step_sel_in,
  input wire [15:0] normal_freq_in,
  input wire normal_rev_in,
  input wire [15:0] multi_speed_freq_in,
  input wire [15:0] normal_accel_in,
  input wire [15:0] normal_decel_in,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [15:0] freq_ref_out,
  output reg run_fwd_out,
  output reg run_rev_out,
  output reg [15:0] accel_time_out,
  output reg [15:0] decel_time_out,
  output reg seq_active_out,
  output reg [3:0] stage_out
);

  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_HOLD = 2'd2;
  localparam ST_DONE = 2'd3;

  // Pin synchronisers
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg [3:0] step_s1_r;
  reg [3:0] step_s2_r;
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      step_s1_r <= 4'h0;
      step_s2_r <= 4'h0;
    end else begin
      sync1_r <= {run_in, wobble_en_in, pid_en_in};
      sync2_r <= sync1_r;
      step_s1_r <= multi_step_sel_in;
      step_s2_r <= step_s1_r;
    end
  end
  wire run_s = sync2_r[2];
  wire wobble_s = sync2_r[1];
  wire pid_s = sync2_r[0];

  // Registers
  reg [2:0] mode_r;
  reg [15:0] stage0_freq_r;
  reg [15:0] accel_r;
  reg [15:0] decel_r;
  reg [15:0] freq_r [1:15];
  reg [15:0] time_r [0:15];
  reg [1:0] dir_r [0:15];

  // hundredths below 300 Hz, tenths above
  function [15:0] clip_freq;
    input [15:0] v;
    reg [15:0] c;
    begin
      c = (v > `FREQ_MAX) ? `FREQ_MAX : v;
      clip_freq = (c > `FREQ_COARSE) ? (c - (c % 16'd10)) : c;
    end
  endfunction

  // AXI write path: address and data accepted in either order
  reg aw_held_r;
  reg w_held_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  wire [11:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_held_r ? wstrb_r : s_axi_wstrb;
  wire have_aw = aw_held_r || (s_axi_awvalid && s_axi_awready);
  wire have_w = w_held_r || (s_axi_wvalid && s_axi_wready);
  wire wr_go = have_aw && have_w && !s_axi_bvalid;
  wire [15:0] wd16 = {ws[1] ? wd[15:8] : 8'h00, ws[0] ? wd[7:0] : 8'h00};
  wire wr_fix = (wa == `OFS_CTRL) || (wa == `OFS_STAGE0_FREQ) || (wa == `OFS_ACCEL) || (wa == `OFS_DECEL)
    || (wa == `OFS_STATUS);
  wire wr_freq = (wa >= `OFS_FREQ_BASE + 12'h004) && (wa < `OFS_FREQ_BASE + 12'h040);
  wire wr_time = (wa >= `OFS_TIME_BASE) && (wa < `OFS_TIME_BASE + 12'h040);
  wire wr_dir = (wa >= `OFS_DIR_BASE) && (wa < `OFS_DIR_BASE + 12'h040);
  wire wr_ok = (wa[1:0] == 2'b00) && (wr_fix || wr_freq || wr_time || wr_dir);
  wire [3:0] widx = wa[5:2];

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      mode_r <= `MODE_OFF;
      stage0_freq_r <= 16'h0000;
      accel_r <= 16'h0064;
      decel_r <= 16'h0064;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ok && wa == `OFS_CTRL && ws[0])
          mode_r <= (wd[2:0] > 3'd6) ? `MODE_OFF : wd[2:0];
        // stage 0 frequency from multi-speed zero
        if (wr_ok && wa == `OFS_STAGE0_FREQ)
          stage0_freq_r <= clip_freq(wd16);
        if (wr_ok && wa == `OFS_ACCEL)
          accel_r <= wd16;
        if (wr_ok && wa == `OFS_DECEL)
          decel_r <= wd16;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_stage
      always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          time_r[g] <= 16'h0000;
          dir_r[g] <= `DIR_STOP;
        end else if (wr_go && wr_ok && widx == g) begin
          // 0.0 to 6000.0 s in tenths
          if (wr_time)
            time_r[g] <= (wd16 > `TIME_MAX) ? `TIME_MAX : wd16;
          // only 0, 1, 2 are stored
          if (wr_dir && ws[0])
            dir_r[g] <= (wd[1:0] == 2'd3) ? `DIR_STOP : wd[1:0];
        end
      end
      if (g > 0) begin : g_freq
        always @(posedge clock_in or negedge rst_n_in) begin
          if (!rst_n_in)
            freq_r[g] <= 16'h0000;
          else if (wr_go && wr_ok && wr_freq && widx == g)
            freq_r[g] <= clip_freq(wd16);
        end
      end
    end
  endgenerate

  // Sequencer
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] stage_r;
  reg [15:0] tenths_r;
  reg [23:0] tick_r;
  reg run_d_r;

  // any nonzero time keeps the program valid
  reg any_time;
  integer i;
  always @* begin
    any_time = 1'b0;
    for (i = 0; i < 16; i = i + 1)
      any_time = any_time | (time_r[i] != 16'h0000);
  end
  wire enabled = (mode_r != `MODE_OFF) && !wobble_s && !pid_s && any_time;
  wire restart_first = (mode_r >= 3'd4);
  wire [1:0] mode_kind = (mode_r >= 3'd4) ? (mode_r[1:0] - 2'd3) : mode_r[1:0];
  wire expire = (tenths_r >= time_r[stage_r]);
  wire [3:0] stage_inc = stage_r + 4'd1;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (enabled && run_s) state_nxt = ST_RUN;
      ST_RUN: begin
        if (!enabled) state_nxt = ST_IDLE;
        else if (!run_s) state_nxt = ST_IDLE;
        else if (expire && stage_r == 4'd15) begin
          if (mode_kind == 2'd1) state_nxt = ST_DONE;
          // single cycle then hold last speed
          else if (mode_kind == 2'd3) state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: if (!enabled || !run_s) state_nxt = ST_IDLE;
      ST_DONE: if (!enabled || !run_s) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      stage_r <= 4'd0;
      tenths_r <= 16'h0000;
      tick_r <= 24'h00_0000;
      run_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      run_d_r <= run_s;
      if (!enabled) begin
        stage_r <= 4'd0;
        tenths_r <= 16'h0000;
        tick_r <= 24'h00_0000;
      end else if (state_r == ST_IDLE && state_nxt == ST_RUN) begin
        tick_r <= 24'h00_0000;
        if (restart_first) begin
          stage_r <= 4'd0;
          tenths_r <= 16'h0000;
        end
        // otherwise the unfinished stage resumes with its elapsed time kept
      end else if (state_r == ST_DONE && !run_s) begin
        // Finished single cycle starts over on next run
        stage_r <= 4'd0;
        tenths_r <= 16'h0000;
      end else if (state_r == ST_RUN && state_nxt == ST_RUN) begin
        if (expire) begin
          // wraps from stage 15 back to 0
          stage_r <= stage_inc;
          tenths_r <= 16'h0000;
          tick_r <= 24'h00_0000;
        end else if (tick_r == TICK_CYC - 1) begin
          tick_r <= 24'h00_0000;
          tenths_r <= tenths_r + 16'd1;
        end else begin
          tick_r <= tick_r + 24'd1;
        end
      end
    end
  end

  wire [15:0] stage_freq = (stage_r == 4'd0) ? stage0_freq_r : freq_r[stage_r];
  wire seq_drive = (state_r == ST_RUN) || (state_r == ST_HOLD);
  // multi-step selects only reach the normal path when sequencer off
  wire [15:0] normal_pick = (step_s2_r != 4'h0) ? multi_speed_freq_in : normal_freq_in;

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freq_ref_out <= 16'h0000;
      run_fwd_out <= 1'b0;
      run_rev_out <= 1'b0;
      accel_time_out <= 16'h0000;
      decel_time_out <= 16'h0000;
      seq_active_out <= 1'b0;
      stage_out <= 4'd0;
    end else begin
      seq_active_out <= enabled;
      stage_out <= stage_r;
      if (enabled) begin
        accel_time_out <= accel_r;
        decel_time_out <= decel_r;
        freq_ref_out <= (seq_drive && dir_r[stage_r] != `DIR_STOP) ? stage_freq : 16'h0000;
        run_fwd_out <= seq_drive && dir_r[stage_r] == `DIR_FWD;
        run_rev_out <= seq_drive && dir_r[stage_r] == `DIR_REV;
      end else begin
        accel_time_out <= normal_accel_in;
        decel_time_out <= normal_decel_in;
        freq_ref_out <= normal_pick;
        run_fwd_out <= run_s && !normal_rev_in;
        run_rev_out <= run_s && normal_rev_in;
      end
    end
  end

  // AXI read path
  assign s_axi_arready = !s_axi_rvalid;
  wire [11:0] ra = s_axi_araddr;
  wire [3:0] ridx = ra[5:2];
  reg [31:0] rd;
  reg rd_ok;
  always @* begin
    rd = 32'h0000_0000;
    rd_ok = (ra[1:0] == 2'b00);
    if (ra == `OFS_CTRL) rd = {29'h0000_0000, mode_r};
    else if (ra == `OFS_STATUS) rd = {21'h00_0000, run_d_r, enabled, stage_r, 3'h0, state_r};
    else if (ra == `OFS_STAGE0_FREQ) rd = {16'h0000, stage0_freq_r};
    else if (ra == `OFS_ACCEL) rd = {16'h0000, accel_r};
    else if (ra == `OFS_DECEL) rd = {16'h0000, decel_r};
    else if (ra >= `OFS_FREQ_BASE + 12'h004 && ra < `OFS_FREQ_BASE + 12'h040) rd = {16'h0000, freq_r[ridx]};
    else if (ra >= `OFS_TIME_BASE && ra < `OFS_TIME_BASE + 12'h040) rd = {16'h0000, time_r[ridx]};
    else if (ra >= `OFS_DIR_BASE && ra < `OFS_DIR_BASE + 12'h040) rd = {30'h0000_0000, dir_r[ridx]};
    else rd_ok = 1'b0;
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // auto_stage_sequencer

// [bench/drive_side_model.sv]
// Model of the drive's run switch and normal reference sources.
// Assumes the bench calls pins() to move the switch and function enables.
`timescale 1ns/10ps
module drive_side_model (
  input wire clock_in,
  output reg run_in,
  output reg wobble_en_in,
  output reg pid_en_in,
  output reg [3:0] multi_step_sel_in,
  output reg [15:0] normal_freq_in,
  output reg normal_rev_in,
  output reg [15:0] multi_speed_freq_in,
  output reg [15:0] normal_accel_in,
  output reg [15:0] normal_decel_in
);
  initial begin
    run_in = 1'b0;
    wobble_en_in = 1'b0;
    pid_en_in = 1'b0;
    multi_step_sel_in = 4'h0;
    normal_freq_in = 16'h0bb8;
    normal_rev_in = 1'b0;
    multi_speed_freq_in = 16'h0123;
    normal_accel_in = 16'h0032;
    normal_decel_in = 16'h0028;
  end
  // Levels move just after an edge, like a switch
  task pins(input r, input w, input p, input [3:0] s);
    begin
      @(posedge clock_in);
      run_in <= r;
      wobble_en_in <= w;
      pid_en_in <= p;
      multi_step_sel_in <= s;
    end
  endtask
endmodule // drive_side_model

// [bench/auto_stage_checker_assertions.sv]
// Checker on the stage sequencer's outputs and read channel.
// Assumes binding to the sequencer top and word writes offered whole.
`timescale 1ns/10ps
module auto_stage_checker (
  input wire clock_in,
  input wire rst_n_in,
  input wire wobble_en_in,
  input wire pid_en_in,
  input wire s_axi_wvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] freq_ref_out,
  input wire run_fwd_out,
  input wire run_rev_out,
  input wire [15:0] accel_time_out,
  input wire seq_active_out,
  input wire [3:0] stage_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Long enough to pass the pin synchronisers
  sequence s_inhibit;
    (wobble_en_in || pid_en_in) [*5];
  endsequence
  sequence s_quiet;
    (seq_active_out && !s_axi_wvalid) [*3];
  endsequence
  AST_INHIBIT: assert property (s_inhibit |=> !seq_active_out)
    else $error("sequencer active while inhibited");
  AST_STOP_ZERO: assert property (seq_active_out && !run_fwd_out && !run_rev_out |-> freq_ref_out == 16'h0000)
    else $error("nonzero reference in a stop stage");
  AST_DIR_EXCL: assert property (!(run_fwd_out && run_rev_out))
    else $error("both directions driven");
  AST_RAMP_HOLD: assert property (s_quiet |=> !seq_active_out || $stable(accel_time_out))
    else $error("ramp time moved while sequencing");
  AST_STAGE_STEP: assert property (seq_active_out && $past(seq_active_out) && $changed(stage_out)
    |-> stage_out == $past(stage_out) + 4'h1 || stage_out == 4'h0)
    else $error("stage skipped");
  AST_IDLE_STAGE0: assert property (!seq_active_out [*2] |-> stage_out == 4'h0)
    else $error("stage kept while disabled");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule // auto_stage_checker
bind auto_stage_sequencer auto_stage_checker u_chk (.*);

// [bench/tb_top.sv]
// Self-checking bench for the stage sequencer over its register bus.
// Assumes TICK_CYC of 10 cycles so a stage time of 5 lasts 51 cycles, 50 counted plus one to expire.
`timescale 1ns/10ps
`include "auto_stage_consts.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top;
  reg clock_in = 1'b0;
  reg rst_n_in = 1'b0;
  wire run_in, wobble_en_in, pid_en_in, normal_rev_in;
  wire [3:0] multi_step_sel_in;
  wire [15:0] normal_freq_in, multi_speed_freq_in, normal_accel_in, normal_decel_in;
  reg [11:0] s_axi_awaddr = 12'h000;
  reg [11:0] s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire run_fwd_out, run_rev_out, seq_active_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] freq_ref_out, accel_time_out, decel_time_out;
  wire [3:0] stage_out;
  integer failures = 0, n_checks = 0, cyc = 0;
  reg pa, pw;
  always #50 clock_in = ~clock_in;
  drive_side_model u_drv (.*);
  auto_stage_sequencer #(.TICK_CYC(10)) u_dut (.*);
  task test_done;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
        @(posedge clock_in);
        pa = pa && !s_axi_awready;
        pw = pw && !s_axi_wready;
        s_axi_awvalid <= pa;
        s_axi_wvalid <= pw;
      end
      do @(posedge clock_in); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, `RESP_OKAY)
    end
  endtask
  task chk_reg(input [11:0] a, input [15:0] e, input [1:0] er);
    begin
      @(posedge clock_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock_in); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock_in); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, {16'h0000, e})
      `CHK(s_axi_rresp, er)
    end
  endtask
  task cfg(input [11:0] o, input [31:0] t, input [31:0] d);
    begin
      wr(`OFS_TIME_BASE + o, t);
      wr(`OFS_DIR_BASE + o, d);
    end
  endtask
  task setmode(input [31:0] m);
    begin
      u_drv.pins(1'b0, 1'b0, 1'b0, 4'h0);
      wr(`OFS_CTRL, 32'h0000_0000);
      wr(`OFS_CTRL, m);
      u_drv.pins(1'b1, 1'b0, 1'b0, 4'h3);
      // Run needs sync, state and output edges before stage 0 shows
      repeat (4) @(posedge clock_in);
    end
  endtask
  // Settle two edges so registered outputs follow the stage
  task wait_st(input [3:0] s);
    begin
      do @(posedge clock_in); while (stage_out !== s);
      repeat (2) @(posedge clock_in);
      #1;
    end
  endtask
  task chk_out(input [15:0] f, input fw, input rv);
    begin
      `CHK(freq_ref_out, f)
      `CHK(run_fwd_out, fw)
      `CHK(run_rev_out, rv)
    end
  endtask
  task bounce;
    begin
      wait_st(4'h1);
      u_drv.pins(1'b0, 1'b0, 1'b0, 4'h3);
      repeat (10) @(posedge clock_in);
      u_drv.pins(1'b1, 1'b0, 1'b0, 4'h3);
      repeat (8) @(posedge clock_in);
      #1;
    end
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    chk_reg(`OFS_CTRL, 16'h0000, `RESP_OKAY);
    chk_reg(`OFS_ACCEL, 16'h0064, `RESP_OKAY);
    chk_reg(`OFS_DECEL, 16'h0064, `RESP_OKAY);
    chk_reg(12'hffc, 16'h0000, `RESP_SLVERR);
    wr(`OFS_FREQ_BASE + 12'h004, 32'h0000_aff8);
    chk_reg(`OFS_FREQ_BASE + 12'h004, 16'h9c40, `RESP_OKAY);
    wr(`OFS_FREQ_BASE + 12'h004, 32'h0000_7535);
    chk_reg(`OFS_FREQ_BASE + 12'h004, 16'h7530, `RESP_OKAY);
    wr(`OFS_TIME_BASE, 32'h0000_fde8);
    chk_reg(`OFS_TIME_BASE, 16'hea60, `RESP_OKAY);
    wr(`OFS_DIR_BASE + 12'h004, 32'h0000_0003);
    chk_reg(`OFS_DIR_BASE + 12'h004, 16'h0000, `RESP_OKAY);
    u_drv.pins(1'b1, 1'b0, 1'b0, 4'h0);
    repeat (6) @(posedge clock_in);
    chk_out(16'h0bb8, 1'b1, 1'b0);
    `CHK(accel_time_out, 16'h0032)
    `CHK(decel_time_out, 16'h0028)
    u_drv.pins(1'b1, 1'b0, 1'b0, 4'h1);
    repeat (6) @(posedge clock_in);
    `CHK(freq_ref_out, 16'h0123)
    wr(`OFS_STAGE0_FREQ, 32'h0000_05dc);
    wr(`OFS_FREQ_BASE + 12'h004, 32'h0000_0fa0);
    wr(`OFS_FREQ_BASE + 12'h008, 32'h0000_0bb8);
    wr(`OFS_FREQ_BASE + 12'h03c, 32'h0000_07d0);
    cfg(12'h000, 32'h0000_0005, 32'h0000_0001);
    cfg(12'h004, 32'h0000_0005, 32'h0000_0002);
    cfg(12'h008, 32'h0000_0005, 32'h0000_0000);
    cfg(12'h03c, 32'h0000_0005, 32'h0000_0001);
    setmode(32'h0000_0003);
    wait_st(4'h0);
    chk_out(16'h05dc, 1'b1, 1'b0);
    `CHK(accel_time_out, 16'h0064)
    `CHK(decel_time_out, 16'h0064)
    wait_st(4'h1);
    chk_out(16'h0fa0, 1'b0, 1'b1);
    wait_st(4'h2);
    chk_out(16'h0000, 1'b0, 1'b0);
    wait_st(4'hf);
    chk_out(16'h07d0, 1'b1, 1'b0);
    repeat (80) @(posedge clock_in);
    chk_out(16'h07d0, 1'b1, 1'b0);
    setmode(32'h0000_0001);
    wait_st(4'hf);
    repeat (70) @(posedge clock_in);
    chk_out(16'h0000, 1'b0, 1'b0);
    setmode(32'h0000_0002);
    bounce;
    `CHK(stage_out, 4'h1)
    wait_st(4'hf);
    wait_st(4'h0);
    chk_out(16'h05dc, 1'b1, 1'b0);
    setmode(32'h0000_0005);
    bounce;
    `CHK(stage_out, 4'h0)
    u_drv.pins(1'b1, 1'b1, 1'b0, 4'h0);
    repeat (6) @(posedge clock_in);
    `CHK(seq_active_out, 1'b0)
    u_drv.pins(1'b1, 1'b0, 1'b1, 4'h0);
    repeat (6) @(posedge clock_in);
    `CHK(seq_active_out, 1'b0)
    u_drv.pins(1'b1, 1'b0, 1'b0, 4'h0);
    repeat (6) @(posedge clock_in);
    `CHK(seq_active_out, 1'b1)
    cfg(12'h000, 32'h0000_0000, 32'h0000_0001);
    cfg(12'h004, 32'h0000_0000, 32'h0000_0002);
    cfg(12'h008, 32'h0000_0000, 32'h0000_0000);
    cfg(12'h03c, 32'h0000_0000, 32'h0000_0001);
    repeat (6) @(posedge clock_in);
    `CHK(seq_active_out, 1'b0)
    chk_reg(`OFS_STATUS, 16'h0400, `RESP_OKAY);
    test_done;
  end
endmodule // tb_top
